// file: sck_edge_sampler.sv
`timescale 1ns/10ps
`default_nettype none

// samples the master's serial clock on operation clock ticks
module sck_edge_sampler (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // sampling
    input wire logic tick_in,
    input wire logic sck_in,
    input wire logic invert_in,
    // edges of the effective clock
    output logic lead_out,
    output logic trail_out
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic eff_now;
    logic eff_prev;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
        end else if (tick_in) begin
            sync1_q <= sck_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign eff_now = sync2_q ^ invert_in;
    assign eff_prev = prev_q ^ invert_in;

    // one pulse per sampled edge; the master keeps under a sixth of
    // the tick rate so no edge slips between two samples
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            lead_out <= 1'b0;
            trail_out <= 1'b0;
        end else begin
            lead_out <= tick_in & eff_prev & ~eff_now;
            trail_out <= tick_in & ~eff_prev & eff_now;
        end
    end

endmodule

`default_nettype wire

// file: spi_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_master_model #(
    parameter int HALF = 8 // half period in clocks, slower than ticks / 6
) (
    // control
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic ckp_in,
    input wire logic dap_in,
    input wire logic lsb_in,
    input wire logic len7_in,
    input wire logic [7:0] tx_in,
    // serial lines
    input wire logic miso_in,
    output logic sck_out,
    output var logic mosi_out,
    // result
    output var logic [7:0] rx_out,
    output var logic busy_out
);
    logic act;
    logic [7:0] r;
    int n;
    int b;
    // clock stands at its idle level outside frames
    assign sck_out = act ? ckp_in : !ckp_in;
    initial begin
        act = 1'b0;
        mosi_out = 1'b0;
        rx_out = 8'h00;
        busy_out = 1'b0;
        forever begin
            @(posedge clk_in);
            if (go_in) begin
                busy_out <= 1'b1;
                r = 8'h00;
                n = len7_in ? 7 : 8;
                for (int i = 0; i < n; i++) begin
                    b = lsb_in ? i : n - 1 - i;
                    if (!dap_in)
                        act <= 1'b1;
                    mosi_out <= tx_in[b];
                    repeat (HALF) @(posedge clk_in);
                    act <= dap_in;
                    r[b] = miso_in;
                    repeat (HALF) @(posedge clk_in);
                    if (dap_in)
                        act <= 1'b0;
                end
                if (dap_in)
                    repeat (HALF) @(posedge clk_in);
                // released line shows the inverse of its last bit
                mosi_out <= !mosi_out;
                rx_out <= r;
                busy_out <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: spi_slave_channel.sv
`timescale 1ns/10ps
`default_nettype none

module spi_slave_channel #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    // operation clock ticks from the prescaler
    input wire logic prescaler_clock_a_in,
    input wire logic prescaler_clock_b_in,
    // serial pins
    input wire logic serial_clock_pin_ch0_in,
    input wire logic serial_in_pin_ch0_in,
    output logic serial_out_pin_ch0_out,
    output logic serial_out_pin_ch0_oe_n_out,
    // interrupt request pulse
    output logic channel0_irq_out
);

    initial begin
        if (DATA_W != 8 || ADDR_W < 3) begin
            $error("spi_slave_channel: unsupported width");
        end
    end

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOADED = 2'b01,
        ST_SHIFT = 2'b10
    } shift_state_t;

    shift_state_t state_q;
    logic per_en_q;
    logic unit_rst;
    logic [3:0] mode_q;
    logic [3:0] comm_q;
    logic out_level_q;
    logic out_enable_q;
    logic run_q;
    logic [7:0] tx_buf_q;
    logic buf_full_q;
    logic [7:0] tx_sh_q;
    logic [7:0] rx_sh_q;
    logic [7:0] rx_data_q;
    logic rx_full_q;
    logic overrun_q;
    logic [3:0] bit_cnt_q;
    logic tick;
    logic lead;
    logic trail;
    logic sample_edge;
    logic shift_edge;
    logic [1:0] op_mode;
    logic tx_mode;
    logic dap;
    logic lsb_first;
    logic [3:0] word_len;
    logic wr_data;
    logic rd_data;
    logic do_load;
    logic do_sample;
    logic do_advance;
    logic word_end;
    logic [7:0] rx_next;

    // most- or least-significant bit of the current word
    function automatic logic pick_bit(input logic [7:0] sh, input logic lsb,
                                      input logic [3:0] len);
        if (lsb) begin
            pick_bit = sh[0];
        end else begin
            pick_bit = sh[3'(len - 4'h1)];
        end
    endfunction

    // finished word aligned to bit 0, unused top bit cleared
    function automatic logic [7:0] align_rx(input logic [7:0] sh,
                                            input logic lsb,
                                            input logic [3:0] len);
        logic [7:0] w;
        w = (lsb && len == spi_slave_pkg::LEN_SHORT) ? (sh >> 1) : sh;
        if (len == spi_slave_pkg::LEN_SHORT) begin
            w[7] = 1'b0;
        end
        align_rx = w;
    endfunction

    // cleared peripheral enable holds all but the enable and read data registers in reset
    assign unit_rst = rst_in | ~per_en_q;

    assign op_mode = mode_q[spi_slave_pkg::MODE_OP_HI:
                            spi_slave_pkg::MODE_OP_LO];
    assign tx_mode = op_mode[1];
    assign dap = comm_q[spi_slave_pkg::COMM_DAP_BIT];
    assign lsb_first = comm_q[spi_slave_pkg::COMM_LSB_BIT];
    assign word_len = comm_q[spi_slave_pkg::COMM_LEN7_BIT] ?
                      spi_slave_pkg::LEN_SHORT : spi_slave_pkg::LEN_LONG;

    // operation clock tick from one of the two prescaler outputs
    assign tick = mode_q[spi_slave_pkg::MODE_CLK_SEL_BIT] ?
                  prescaler_clock_b_in : prescaler_clock_a_in;

    sck_edge_sampler u_sampler (
        .clk_in(clk_in),
        .rst_in(unit_rst),
        .tick_in(tick),
        .sck_in(serial_clock_pin_ch0_in),
        .invert_in(comm_q[spi_slave_pkg::COMM_CKP_BIT]),
        .lead_out(lead),
        .trail_out(trail)
    );

    // phase 1 samples on the leading edge, phase 0 on the trailing
    assign sample_edge = dap ? lead : trail;
    assign shift_edge = dap ? trail : lead;

    assign wr_data = reg_wr_in &&
                     reg_addr_in == ADDR_W'(spi_slave_pkg::ADDR_DATA);
    assign rd_data = reg_rd_in &&
                     reg_addr_in == ADDR_W'(spi_slave_pkg::ADDR_DATA);

    // the channel moves on the master's clock edges, except the phase 1 load in idle
    always_comb begin
        do_load = 1'b0;
        do_sample = 1'b0;
        do_advance = 1'b0;
        if (run_q && op_mode != spi_slave_pkg::OP_OFF) begin
            case (state_q)
                ST_IDLE: begin
                    // phase 1 presents the first bit before any edge;
                    // the word must be loaded already
                    if (dap) begin
                        do_load = buf_full_q || !tx_mode || lead;
                        do_sample = lead;
                    end else begin
                        do_load = lead;
                    end
                end
                ST_LOADED: begin
                    do_sample = sample_edge;
                    do_advance = dap ? 1'b0 : 1'b0;
                end
                ST_SHIFT: begin
                    do_sample = sample_edge;
                    do_advance = shift_edge;
                end
                default: begin
                    do_load = 1'b0;
                end
            endcase
        end
    end

    assign word_end = do_sample && bit_cnt_q == 4'(word_len - 4'h1);

    always_comb begin
        if (lsb_first) begin
            rx_next = {serial_in_pin_ch0_in, rx_sh_q[7:1]};
        end else begin
            rx_next = {rx_sh_q[6:0], serial_in_pin_ch0_in};
        end
    end

    // peripheral enable lives outside the unit reset
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            per_en_q <= spi_slave_pkg::RST_PER_ENABLE;
        end else if (reg_wr_in &&
                     reg_addr_in == ADDR_W'(spi_slave_pkg::ADDR_PER_ENABLE)) begin
            per_en_q <= reg_wdata_in[0];
        end
    end

    // configuration registers
    always_ff @(posedge clk_in) begin
        if (unit_rst) begin
            mode_q <= spi_slave_pkg::RST_MODE;
            comm_q <= spi_slave_pkg::RST_COMM;
            out_level_q <= spi_slave_pkg::RST_OUT_LEVEL;
            out_enable_q <= spi_slave_pkg::RST_OUT_ENABLE;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                ADDR_W'(spi_slave_pkg::ADDR_MODE): mode_q <= reg_wdata_in[3:0];
                ADDR_W'(spi_slave_pkg::ADDR_COMM): comm_q <= reg_wdata_in[3:0];
                ADDR_W'(spi_slave_pkg::ADDR_OUT_LEVEL): out_level_q <= reg_wdata_in[0];
                ADDR_W'(spi_slave_pkg::ADDR_OUT_ENABLE): out_enable_q <= reg_wdata_in[0];
                default: out_enable_q <= out_enable_q;
            endcase
        end
    end

    // start bit runs the channel, stop bit halts it
    always_ff @(posedge clk_in) begin
        if (unit_rst) begin
            run_q <= 1'b0;
        end else if (reg_wr_in &&
                     reg_addr_in == ADDR_W'(spi_slave_pkg::ADDR_START)) begin
            if (reg_wdata_in[spi_slave_pkg::START_STOP_BIT]) begin
                run_q <= 1'b0;
            end else if (reg_wdata_in[spi_slave_pkg::START_RUN_BIT]) begin
                run_q <= 1'b1;
            end
        end
    end

    // transmit buffer; a write while full overwrites the pending word,
    // and a write in the load cycle keeps the buffer full
    always_ff @(posedge clk_in) begin
        if (unit_rst) begin
            tx_buf_q <= spi_slave_pkg::RST_BYTE;
            buf_full_q <= 1'b0;
        end else if (wr_data) begin
            tx_buf_q <= reg_wdata_in;
            buf_full_q <= 1'b1;
        end else if (do_load) begin
            buf_full_q <= 1'b0;
        end
    end

    // shift sequencing
    always_ff @(posedge clk_in) begin
        if (unit_rst || !run_q) begin
            state_q <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            tx_sh_q <= spi_slave_pkg::RST_BYTE;
            rx_sh_q <= spi_slave_pkg::RST_BYTE;
        end else begin
            if (do_load) begin
                tx_sh_q <= tx_buf_q;
                state_q <= ST_SHIFT;
            end else if (do_advance) begin
                // bit order decides the shift direction
                tx_sh_q <= lsb_first ? (tx_sh_q >> 1) : (tx_sh_q << 1);
            end
            if (do_sample) begin
                rx_sh_q <= rx_next;
                bit_cnt_q <= word_end ? 4'h0 : 4'(bit_cnt_q + 4'h1);
            end
            if (word_end) begin
                state_q <= ST_IDLE;
            end
        end
    end

    // received word and overrun; the set wins over a read
    always_ff @(posedge clk_in) begin
        if (unit_rst) begin
            rx_data_q <= spi_slave_pkg::RST_BYTE;
            rx_full_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            if (word_end) begin
                rx_data_q <= align_rx(rx_next, lsb_first, word_len);
                rx_full_q <= 1'b1;
                if (rx_full_q && !rd_data) begin
                    overrun_q <= 1'b1;
                end
            end else if (rd_data) begin
                rx_full_q <= 1'b0;
            end
            if (!(word_end && rx_full_q && !rd_data) && reg_wr_in &&
                reg_addr_in == ADDR_W'(spi_slave_pkg::ADDR_STATUS) &&
                reg_wdata_in[spi_slave_pkg::STAT_OVF_BIT]) begin
                overrun_q <= 1'b0;
            end
        end
    end

    // interrupt source is read when the event fires, so a late change
    // of the select bit misses the final word
    always_ff @(posedge clk_in) begin
        if (unit_rst) begin
            channel0_irq_out <= 1'b0;
        end else if (tx_mode &&
                     mode_q[spi_slave_pkg::MODE_IRQ_SRC_BIT]) begin
            channel0_irq_out <= do_load;
        end else begin
            // receive-only always reports transfer end
            channel0_irq_out <= word_end;
        end
    end

    // data out is driven only when transmitting
    always_ff @(posedge clk_in) begin
        if (unit_rst) begin
            serial_out_pin_ch0_out <= spi_slave_pkg::RST_OUT_LEVEL;
            serial_out_pin_ch0_oe_n_out <= 1'b1;
        end else if (!tx_mode) begin
            serial_out_pin_ch0_out <= spi_slave_pkg::RST_OUT_LEVEL;
            serial_out_pin_ch0_oe_n_out <= 1'b1;
        end else begin
            serial_out_pin_ch0_oe_n_out <= ~out_enable_q;
            if (state_q == ST_IDLE && !do_load) begin
                serial_out_pin_ch0_out <= out_level_q;
            end else if (do_load) begin
                serial_out_pin_ch0_out <= pick_bit(tx_buf_q, lsb_first,
                                                   word_len);
            end else if (do_advance) begin
                serial_out_pin_ch0_out <= pick_bit(lsb_first ?
                    (tx_sh_q >> 1) : (tx_sh_q << 1), lsb_first, word_len);
            end
        end
    end

    // read data one cycle after the strobe, zero when unmapped
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            reg_rdata_out <= '0;
        end else if (reg_rd_in) begin
            case (reg_addr_in)
                ADDR_W'(spi_slave_pkg::ADDR_DATA): reg_rdata_out <= rx_data_q;
                ADDR_W'(spi_slave_pkg::ADDR_MODE): reg_rdata_out <= {4'h0, mode_q};
                ADDR_W'(spi_slave_pkg::ADDR_COMM): reg_rdata_out <= {4'h0, comm_q};
                ADDR_W'(spi_slave_pkg::ADDR_STATUS): reg_rdata_out <= {4'h0,
                    rx_full_q, overrun_q, buf_full_q, state_q != ST_IDLE};
                ADDR_W'(spi_slave_pkg::ADDR_OUT_LEVEL):
                    reg_rdata_out <= {7'h00, out_level_q};
                ADDR_W'(spi_slave_pkg::ADDR_OUT_ENABLE):
                    reg_rdata_out <= {7'h00, out_enable_q};
                ADDR_W'(spi_slave_pkg::ADDR_START):
                    reg_rdata_out <= {7'h00, run_q};
                ADDR_W'(spi_slave_pkg::ADDR_PER_ENABLE):
                    reg_rdata_out <= {7'h00, per_en_q};
                default: reg_rdata_out <= '0;
            endcase
        end else begin
            reg_rdata_out <= '0;
        end
    end

endmodule

`default_nettype wire

// file: spi_slave_channel_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module spi_slave_channel_monitor #(
    parameter int ADDR_W = 4,
    parameter int DATA_W = 8
) (
    // watched ports
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic prescaler_clock_a_in,
    input wire logic prescaler_clock_b_in,
    input wire logic serial_clock_pin_ch0_in,
    input wire logic serial_in_pin_ch0_in,
    input wire logic serial_out_pin_ch0_out,
    input wire logic serial_out_pin_ch0_oe_n_out,
    input wire logic channel0_irq_out
);
    default clocking @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    logic [3:0] mode_q;
    logic [3:0] comm_q;
    logic per_q;
    logic run_q;
    logic sck_q;
    logic [3:0] tk_q;
    logic [4:0] cnt_q;
    logic moved_w;
    logic start_w;
    logic end_w;
    assign moved_w = serial_clock_pin_ch0_in != sck_q;
    assign start_w = reg_wr_in && reg_wdata_in[0] &&
                     reg_addr_in == spi_slave_pkg::ADDR_START;
    assign end_w = mode_q[3:2] == spi_slave_pkg::OP_RX || !mode_q[0];
    // mirror of what software configured
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            per_q <= 1'b0;
        end else if (reg_wr_in &&
                     reg_addr_in == spi_slave_pkg::ADDR_PER_ENABLE) begin
            per_q <= reg_wdata_in[0];
        end
    end
    always_ff @(posedge clk_in) begin
        if (rst_in || !per_q) begin
            mode_q <= 4'h0;
            comm_q <= 4'h0;
            run_q <= 1'b0;
        end else if (reg_wr_in) begin
            case (reg_addr_in)
                spi_slave_pkg::ADDR_MODE: mode_q <= reg_wdata_in[3:0];
                spi_slave_pkg::ADDR_COMM: comm_q <= reg_wdata_in[3:0];
                spi_slave_pkg::ADDR_START: begin
                    run_q <= (run_q || reg_wdata_in[0]) && !reg_wdata_in[1];
                end
                default: ;
            endcase
        end
    end
    // selected ticks and serial clock changes since the last event
    always_ff @(posedge clk_in) begin
        sck_q <= serial_clock_pin_ch0_in;
        if (rst_in || moved_w)
            tk_q <= 4'h0;
        else if ((mode_q[1] ? prescaler_clock_b_in : prescaler_clock_a_in)
                 && tk_q != 4'hF)
            tk_q <= tk_q + 4'h1;
    end
    always_ff @(posedge clk_in) begin
        if (rst_in || channel0_irq_out || start_w)
            cnt_q <= 5'h00;
        else if (moved_w && cnt_q != 5'h1F)
            cnt_q <= cnt_q + 5'h01;
    end
    sequence s_unmapped_read;
        reg_rd_in && reg_addr_in > spi_slave_pkg::ADDR_PER_ENABLE;
    endsequence
    sequence s_word_end;
        channel0_irq_out && end_w && run_q;
    endsequence
    a_unmapped_zero: assert property (s_unmapped_read |=> reg_rdata_out == '0)
        else $error("unmapped read returned data");
    a_rdata_window: assert property (!$past(reg_rd_in) |-> reg_rdata_out == '0)
        else $error("read data outside its cycle");
    a_irq_pulse: assert property (channel0_irq_out |=> !channel0_irq_out)
        else $error("interrupt longer than one cycle");
    a_stopped_quiet: assert property (!run_q && !$past(run_q) |-> !channel0_irq_out)
        else $error("interrupt while channel stopped");
    a_rx_only_released: assert property (mode_q[3:2] == spi_slave_pkg::OP_RX &&
        $past(mode_q[3:2]) == spi_slave_pkg::OP_RX |-> serial_out_pin_ch0_oe_n_out)
        else $error("data out driven in receive only mode");
    a_unit_held: assert property (!per_q && !$past(per_q) |-> !channel0_irq_out &&
        serial_out_pin_ch0_oe_n_out && serial_out_pin_ch0_out)
        else $error("unit active while disabled");
    a_end_irq_prompt: assert property (s_word_end |-> tk_q <= 4'h8)
        else $error("transfer end interrupt not tied to last edge");
    a_word_edges: assert property (s_word_end |-> cnt_q >= (comm_q[3] ? 5'h0D : 5'h0F))
        else $error("word ended before its length of clock edges");
endmodule
bind spi_slave_channel spi_slave_channel_monitor #(
    .ADDR_W(ADDR_W), .DATA_W(DATA_W)
) mon (
    .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .prescaler_clock_a_in(prescaler_clock_a_in),
    .prescaler_clock_b_in(prescaler_clock_b_in),
    .serial_clock_pin_ch0_in(serial_clock_pin_ch0_in),
    .serial_in_pin_ch0_in(serial_in_pin_ch0_in),
    .serial_out_pin_ch0_out(serial_out_pin_ch0_out),
    .serial_out_pin_ch0_oe_n_out(serial_out_pin_ch0_oe_n_out),
    .channel0_irq_out(channel0_irq_out)
);
`default_nettype wire

// file: spi_slave_pkg.sv
package spi_slave_pkg;

    // register indices on the plain register port
    localparam logic [3:0] ADDR_DATA = 4'h0;
    localparam logic [3:0] ADDR_MODE = 4'h1;
    localparam logic [3:0] ADDR_COMM = 4'h2;
    localparam logic [3:0] ADDR_STATUS = 4'h3;
    localparam logic [3:0] ADDR_OUT_LEVEL = 4'h4;
    localparam logic [3:0] ADDR_OUT_ENABLE = 4'h5;
    localparam logic [3:0] ADDR_START = 4'h6;
    localparam logic [3:0] ADDR_PER_ENABLE = 4'h7;

    // channel_mode_reg fields
    localparam int MODE_IRQ_SRC_BIT = 0;
    localparam int MODE_CLK_SEL_BIT = 1;
    localparam int MODE_OP_LO = 2;
    localparam int MODE_OP_HI = 3;

    // comm_setting_reg fields
    localparam int COMM_DAP_BIT = 0;
    localparam int COMM_CKP_BIT = 1;
    localparam int COMM_LSB_BIT = 2;
    localparam int COMM_LEN7_BIT = 3;

    // channel_status_reg fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_BFF_BIT = 1;
    localparam int STAT_OVF_BIT = 2;
    localparam int STAT_RXF_BIT = 3;

    // channel_start_reg fields
    localparam int START_RUN_BIT = 0;
    localparam int START_STOP_BIT = 1;

    // operating modes held in channel_mode_reg
    localparam logic [1:0] OP_OFF = 2'h0;
    localparam logic [1:0] OP_RX = 2'h1;
    localparam logic [1:0] OP_TX = 2'h2;
    localparam logic [1:0] OP_TXRX = 2'h3;

    // word lengths
    localparam logic [3:0] LEN_SHORT = 4'h7;
    localparam logic [3:0] LEN_LONG = 4'h8;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_MODE = 4'h0;
    localparam logic [3:0] RST_COMM = 4'h0;
    localparam logic RST_OUT_LEVEL = 1'b1;
    localparam logic RST_OUT_ENABLE = 1'b0;
    localparam logic RST_PER_ENABLE = 1'b0;

endpackage

// file: tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk_in, rst_in, reg_wr, reg_rd, go, tick_a, tick_b;
    logic sck, mosi, sout, oe_n, irq, miso, mbusy, sck_d;
    logic [3:0] addr, comm;
    logic [7:0] wdata, rdata, mtx, mrx, mk;
    logic [7:0] tv [5];
    logic [3:0] cv [5];
    int failures, n_checks, irq_n, edges, irq_edges;
    assign miso = oe_n ? !sout : sout;
    spi_slave_channel dut (
        .clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(rdata), .prescaler_clock_a_in(tick_a),
        .prescaler_clock_b_in(tick_b), .serial_clock_pin_ch0_in(sck),
        .serial_in_pin_ch0_in(mosi), .serial_out_pin_ch0_out(sout),
        .serial_out_pin_ch0_oe_n_out(oe_n), .channel0_irq_out(irq)
    );
    spi_master_model master (
        .clk_in(clk_in), .go_in(go), .ckp_in(comm[1]), .dap_in(comm[0]),
        .lsb_in(comm[2]), .len7_in(comm[3]), .tx_in(mtx), .miso_in(miso),
        .sck_out(sck), .mosi_out(mosi), .rx_out(mrx), .busy_out(mbusy)
    );
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = !clk_in;
    end
    // interrupt count and serial clock edges seen at the interrupt
    always @(posedge clk_in) begin
        sck_d <= sck;
        if (go)
            edges <= 0;
        else if (sck !== sck_d)
            edges <= edges + 1;
        if (go)
            irq_n <= 0;
        else if (irq === 1'b1) begin
            irq_n <= irq_n + 1;
            irq_edges <= edges;
        end
    end
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic w_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr <= a;
        wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] m,
                        input logic [7:0] e);
        @(posedge clk_in);
        addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        @(negedge clk_in);
        chk(rdata & m, e);
    endtask
    task automatic cfg(input logic [3:0] m, input logic [3:0] c);
        w_reg(spi_slave_pkg::ADDR_START, 8'h02);
        w_reg(spi_slave_pkg::ADDR_MODE, {4'h0, m});
        w_reg(spi_slave_pkg::ADDR_COMM, {4'h0, c});
        comm <= c;
        repeat (8) @(posedge clk_in);
        w_reg(spi_slave_pkg::ADDR_START, 8'h01);
    endtask
    task automatic xfer(input logic [7:0] t);
        int k;
        @(posedge clk_in);
        mtx <= t;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        k = 0;
        do begin
            @(negedge clk_in);
            k++;
        end while (mbusy !== 1'b0 && k < 400);
        if (k == 400) begin
            failures++;
            summarize();
        end
        repeat (4) @(posedge clk_in);
    endtask
    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {rst_in, tick_a} = 2'b11;
        {reg_wr, reg_rd, go, tick_b} = 4'h0;
        {addr, comm, wdata, mtx} = 24'h000000;
        tv = '{8'hA5, 8'h5A, 8'hC3, 8'h96, 8'h0F};
        cv = '{4'h0, 4'h3, 4'h6, 4'h9, 4'hC};
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        rchk(spi_slave_pkg::ADDR_STATUS, 8'hFF, 8'h00);
        rchk(4'h9, 8'hFF, 8'h00);
        $display("test reset and unmapped done");
        w_reg(spi_slave_pkg::ADDR_PER_ENABLE, 8'h01);
        w_reg(spi_slave_pkg::ADDR_OUT_ENABLE, 8'h01);
        for (int r = 0; r < 5; r++) begin
            cfg(4'hC, cv[r]);
            mk = cv[r][3] ? 8'h7F : 8'hFF;
            w_reg(spi_slave_pkg::ADDR_DATA, tv[r]);
            rchk(spi_slave_pkg::ADDR_STATUS, {6'h0, !cv[r][0], 1'b0},
                 {6'h0, !cv[r][0], 1'b0});
            xfer(~tv[r]);
            chk(mrx, tv[r] & mk);
            chk(8'(irq_edges), (mk[7] ? 8'h10 : 8'h0E) - {7'h0, cv[r][0]});
            rchk(spi_slave_pkg::ADDR_DATA, 8'hFF, ~tv[r] & mk);
        end
        chk({6'h0, oe_n, sout}, 8'h01);
        $display("test formats done");
        cfg(4'hD, 4'h0);
        w_reg(spi_slave_pkg::ADDR_DATA, 8'h11);
        w_reg(spi_slave_pkg::ADDR_DATA, 8'h22);
        xfer(8'h00);
        chk(mrx, 8'h22);
        chk(8'(irq_edges), 8'h01);
        rchk(spi_slave_pkg::ADDR_DATA, 8'hFF, 8'h00);
        $display("test overwrite and buffer empty done");
        cfg(4'h4, 4'h0);
        xfer(8'h81);
        chk(8'(irq_edges), 8'h10);
        chk({7'h0, oe_n}, 8'h01);
        xfer(8'h7E);
        rchk(spi_slave_pkg::ADDR_STATUS, 8'h0C, 8'h0C);
        rchk(spi_slave_pkg::ADDR_DATA, 8'hFF, 8'h7E);
        w_reg(spi_slave_pkg::ADDR_STATUS, 8'h04);
        rchk(spi_slave_pkg::ADDR_STATUS, 8'h04, 8'h00);
        $display("test receive only overrun done");
        cfg(4'hE, 4'h0);
        w_reg(spi_slave_pkg::ADDR_DATA, 8'h33);
        xfer(8'h00);
        chk(8'(irq_n), 8'h00);
        tick_b <= 1'b1;
        xfer(8'h00);
        chk(mrx, 8'h33);
        chk(8'(irq_n), 8'h01);
        $display("test clock select done");
        w_reg(spi_slave_pkg::ADDR_START, 8'h02);
        w_reg(spi_slave_pkg::ADDR_DATA, 8'h44);
        xfer(8'h00);
        chk(8'(irq_n), 8'h00);
        w_reg(spi_slave_pkg::ADDR_PER_ENABLE, 8'h00);
        w_reg(spi_slave_pkg::ADDR_PER_ENABLE, 8'h01);
        rchk(spi_slave_pkg::ADDR_STATUS, 8'hFF, 8'h00);
        $display("test stop and unit reset done");
        summarize();
    end
endmodule
`default_nettype wire
